// *** hdl/crossing_pulse_irq_bits.sv ***
// pulse-output and forward zero-crossing interrupt flags
// assumes a single core_clk, a plain register port and a host that
// watches the active-low interrupt output
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module crossing_pulse_irq_bits #(
  parameter int SAMPLE_W = irq_bits_pkg::SAMPLE_W_DEF
) (
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rstn,
  // register port
  input  wire logic [irq_bits_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [irq_bits_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [irq_bits_pkg::DATA_W-1:0] reg_rdata,
  // pulse output pin, asynchronous to core_clk
  input  wire logic                            pulse_output_one,
  // current samples: a, b, c, neutral
  input  wire logic [SAMPLE_W-1:0]             phase_a_current,
  input  wire logic [SAMPLE_W-1:0]             phase_b_current,
  input  wire logic [SAMPLE_W-1:0]             phase_c_current,
  input  wire logic [SAMPLE_W-1:0]             neutral_current,
  input  wire logic                            sample_valid,
  // interrupt to the host
  output logic                                 irq_out_low
);
  import irq_bits_pkg::*;

  // -------------------------------------------------------------
  // parameter check
  // -------------------------------------------------------------
  // magnitude compare needs a sign bit and fits the data word
  if (SAMPLE_W < 2 || SAMPLE_W > DATA_W) begin : g_bad_width
    $error("SAMPLE_W must lie between 2 and the data width");
  end

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic [2:0]          pin_sync;  // pulse pin synchroniser
    logic                pulse_lvl; // accepted pulse level
    logic [DATA_W-1:0]   flags;     // sticky interrupt flags
    logic [DATA_W-1:0]   enable;    // per-flag enables
    logic [SAMPLE_W-1:0] threshold; // crossing magnitude threshold
    logic [DATA_W-1:0]   rdata;     // read data, one cycle
    logic                irq_low;   // interrupt pin, active low
  } top_s;

  top_s q;       // registered state
  top_s next_q;  // next state

  // -------------------------------------------------------------
  // crossing detectors, one per channel
  // -------------------------------------------------------------
  logic [CHAN_N-1:0][SAMPLE_W-1:0] chan_sample; // a, b, c, neutral
  logic [CHAN_N-1:0]               cross_hit;   // crossing events

  // order matches flag bits 4 upward
  assign chan_sample[0] = phase_a_current;
  assign chan_sample[1] = phase_b_current;
  assign chan_sample[2] = phase_c_current;
  assign chan_sample[3] = neutral_current;

  // one detector per channel shares the threshold register
  for (genvar i = 0; i < CHAN_N; i++) begin : g_chan
    crossing_if #(.W(SAMPLE_W)) cx ();

    assign cx.sample    = chan_sample[i];
    assign cx.valid     = sample_valid;
    assign cx.threshold = q.threshold;
    assign cross_hit[i] = cx.hit;

    crossing_detect #(
      .W        (SAMPLE_W)
    ) u_det (
      .core_clk (core_clk),
      .rstn     (rstn),
      .cx       (cx.det)
    );
  end

  // -------------------------------------------------------------
  // event decode
  // -------------------------------------------------------------
  logic              pin_agree;  // second and third stage agree
  logic              pulse_rise; // accepted low to high change
  logic [DATA_W-1:0] set_bits;   // flags set this cycle
  logic [DATA_W-1:0] clr_bits;   // flags cleared this cycle
  logic              wr_status;  // write to status register
  logic              rd_status;  // read of status register

  // pulse edge counts once the late stages agree on high
  always_comb begin
    pin_agree  = (q.pin_sync[1] == q.pin_sync[2]);
    pulse_rise = pin_agree && q.pin_sync[2] && !q.pulse_lvl;
  end

  // gather the set requests of every source
  always_comb begin
    set_bits            = '0;
    set_bits[PULSE_BIT] = pulse_rise;
    set_bits[NEUTRAL_BIT] = cross_hit[NEUTRAL_BIT - CROSS_LO_BIT];
    set_bits[PHASE_C_BIT] = cross_hit[PHASE_C_BIT - CROSS_LO_BIT];
    set_bits[PHASE_B_BIT] = cross_hit[PHASE_B_BIT - CROSS_LO_BIT];
    set_bits[PHASE_A_BIT] = cross_hit[PHASE_A_BIT - CROSS_LO_BIT];
  end

  // clears: write one to a flag, or read the status register
  always_comb begin
    wr_status = reg_wr && (reg_addr == REG_STATUS);
    rd_status = reg_rd && (reg_addr == REG_STATUS);
    clr_bits  = '0;
    if (wr_status) begin
      clr_bits = reg_wdata & FLAG_MASK;
    end
    if (rd_status) begin
      clr_bits = FLAG_MASK;
    end
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    next_q = q;

    // three-stage pin synchroniser, first stage feeds only the second
    next_q.pin_sync = {q.pin_sync[1:0], pulse_output_one};

    // accept a pin level only when the late stages agree
    if (pin_agree) begin
      next_q.pulse_lvl = q.pin_sync[2];
    end

    // sticky flags: a set in the clearing cycle wins
    next_q.flags = ((q.flags & ~clr_bits) | set_bits) & FLAG_MASK;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        REG_ENABLE: begin
          // cleared enables mask their flags off the interrupt pin
          next_q.enable = reg_wdata & FLAG_MASK;
        end
        REG_THRESH: begin
          // magnitude that the peak since the last crossing must exceed
          next_q.threshold = reg_wdata[SAMPLE_W-1:0];
        end
        default: begin
          // status handled above, others ignore writes
          next_q.threshold = q.threshold;
        end
      endcase
    end

    // read data stands for exactly one cycle after the strobe
    next_q.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: begin
          // flags as they stood before this read cleared them
          next_q.rdata = q.flags;
        end
        REG_ENABLE: begin
          next_q.rdata = q.enable;
        end
        REG_THRESH: begin
          next_q.rdata = DATA_W'(q.threshold);
        end
        REG_LIVE: begin
          // live pin level and interrupt request
          next_q.rdata[LIVE_PULSE_BIT] = q.pulse_lvl;
          next_q.rdata[LIVE_IRQ_BIT]   = !q.irq_low;
        end
        default: begin
          // unmapped index reads as zero
          next_q.rdata = '0;
        end
      endcase
    end

    // pin low while any enabled flag is set, high once all clear
    next_q.irq_low = ~|(next_q.flags & next_q.enable);
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  // reset leaves all flags clear and the pin released high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q.pin_sync  <= 3'h0;
      q.pulse_lvl <= 1'b0;
      q.flags     <= STATUS_RESET;
      q.enable    <= ENABLE_RESET;
      q.threshold <= THRESH_RESET[SAMPLE_W-1:0];
      q.rdata     <= '0;
      q.irq_low   <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // -------------------------------------------------------------
  // outputs, straight from flip-flops
  // -------------------------------------------------------------
  // the clearing write lowers the request in the same edge
  assign irq_out_low = q.irq_low;
  assign reg_rdata   = q.rdata;

endmodule : crossing_pulse_irq_bits

// *** hdl/irq_bits_pkg.sv ***
// constants shared by the crossing and pulse interrupt logic
// assumes a word-wide register port with one-cycle strobes
package irq_bits_pkg;

  // -------------------------------------------------------------
  // register port geometry
  // -------------------------------------------------------------
  localparam int          ADDR_W        = 4;    // register index width
  localparam int          DATA_W        = 32;   // register data width
  localparam int          SAMPLE_W_DEF  = 24;   // default sample width
  localparam int          CHAN_N        = 4;    // crossing channels

  // -------------------------------------------------------------
  // register indices
  // -------------------------------------------------------------
  localparam logic [3:0]  REG_STATUS    = 4'h0; // sticky flags
  localparam logic [3:0]  REG_ENABLE    = 4'h1; // per-flag enables
  localparam logic [3:0]  REG_THRESH    = 4'h2; // crossing threshold
  localparam logic [3:0]  REG_LIVE      = 4'h3; // live pin levels

  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int          PULSE_BIT     = 8;    // pulse one flag
  localparam int          NEUTRAL_BIT   = 7;    // neutral crossing
  localparam int          PHASE_C_BIT   = 6;    // phase c crossing
  localparam int          PHASE_B_BIT   = 5;    // phase b crossing
  localparam int          PHASE_A_BIT   = 4;    // phase a crossing
  localparam int          CROSS_LO_BIT  = 4;    // channel 0 flag bit
  localparam int          LIVE_PULSE_BIT = 0;   // filtered pulse level
  localparam int          LIVE_IRQ_BIT  = 1;    // interrupt request
  localparam logic [31:0] FLAG_MASK     = 32'h000001F0; // flag bits

  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [31:0] STATUS_RESET  = 32'h00000000;
  localparam logic [31:0] ENABLE_RESET  = 32'h00000000;
  localparam logic [31:0] THRESH_RESET  = 32'h00000000;

endpackage : irq_bits_pkg

// *** hdl/crossing_if.sv ***
// bundle between the top and one zero-crossing detector
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface crossing_if #(
  parameter int W = 24
);
  logic [W-1:0] sample;     // signed current sample
  logic         valid;      // sample strobe
  logic [W-1:0] threshold;  // crossing magnitude threshold
  logic         hit;        // one-cycle forward crossing event

  // detector end
  modport det  (input sample, input valid, input threshold,
                output hit);
  // feeding end
  modport feed (output sample, output valid, output threshold,
                input hit);
endinterface : crossing_if

// *** hdl/crossing_detect.sv ***
// forward zero-crossing detector for one current channel
// assumes samples arrive as two's complement words on core_clk
`timescale 1ns/1ps
module crossing_detect #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic      core_clk,
  input  wire logic      rstn,
  // sample side
  crossing_if.det        cx
);
  import irq_bits_pkg::*;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic         neg;   // last sample was negative
    logic [W-1:0] peak;  // largest magnitude since last crossing
    logic         hit;   // crossing event pulse
  } det_s;

  det_s q;       // registered state
  det_s next_q;  // next state

  // next state: track peak, fire on negative to non-negative
  always_comb begin
    logic [W-1:0] mag;
    logic [W-1:0] top;
    mag        = cx.sample[W-1] ? (-cx.sample) : cx.sample;
    top        = (mag > q.peak) ? mag : q.peak;
    next_q     = q;
    next_q.hit = 1'b0;
    if (cx.valid) begin
      if (cx.sample[W-1]) begin
        // negative half: keep building the peak
        next_q.neg  = 1'b1;
        next_q.peak = top;
      end else begin
        // forward crossing counts only above threshold
        next_q.hit  = q.neg && (top > cx.threshold);
        next_q.neg  = 1'b0;
        next_q.peak = q.neg ? mag : top;
      end
    end
  end

  // register the state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign cx.hit = q.hit;

endmodule : crossing_detect

// *** sim/irq_host_model.sv ***
// host that watches the active-low interrupt output
// assumes one core_clk shared with the block
`timescale 1ns/1ps
module irq_host_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // interrupt from the block
  input  wire logic irq_out_low,
  // number of interrupts taken
  output int        irq_falls
);
  logic last_irq;  // level seen one edge earlier

  // count each high to low step of the request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      last_irq  <= 1'b1;
      irq_falls <= 0;
    end else begin
      last_irq <= irq_out_low;
      if (last_irq && !irq_out_low) begin
        irq_falls <= irq_falls + 1;
      end
    end
  end
endmodule : irq_host_model

// *** sim/crossing_pulse_irq_bits_chk.sv ***
// concurrent checks on the interrupt flag block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module crossing_pulse_irq_bits_chk (
  // clock and reset
  input wire logic                            core_clk,
  input wire logic                            rstn,
  // register port
  input wire logic [irq_bits_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [irq_bits_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                            reg_wr,
  input wire logic                            reg_rd,
  input wire logic [irq_bits_pkg::DATA_W-1:0] reg_rdata,
  // pulse pin and interrupt
  input wire logic                            pulse_output_one,
  input wire logic                            irq_out_low
);
  import irq_bits_pkg::*;
  logic [31:0] en;  // shadow of the enable register

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // follow enable writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en <= '0;
    end else if (reg_wr && reg_addr == REG_ENABLE) begin
      en <= reg_wdata & FLAG_MASK;
    end
  end

  sequence s_stat_rd;
    reg_rd && reg_addr == REG_STATUS;
  endsequence
  sequence s_en_off;
    reg_wr && reg_addr == REG_ENABLE && (reg_wdata & FLAG_MASK) == 0;
  endsequence

  a_mask_all_quiet: assert property (s_en_off |=> irq_out_low)
    else $error("interrupt low with every source masked");
  a_low_has_cause: assert property (
    s_stat_rd ##1 (reg_rdata & en) != 0 |-> !$past(irq_out_low))
    else $error("enabled flag set but interrupt high");
  a_high_no_cause: assert property (
    s_stat_rd ##1 (reg_rdata & en) == 0 |-> $past(irq_out_low))
    else $error("interrupt low without enabled flag");
  a_flag_bits_only: assert property (
    s_stat_rd |=> (reg_rdata & ~FLAG_MASK) == 0)
    else $error("status shows bits outside the flags");
  a_irq_held_low: assert property (
    !irq_out_low && !reg_wr && !(reg_rd && reg_addr == REG_STATUS)
    |=> !irq_out_low) else $error("interrupt released with no clear");
  a_fall_needs_en: assert property ($fell(irq_out_low) |-> en != 0)
    else $error("interrupt fell with all sources masked");
  a_pulse_to_irq: assert property (
    $rose(pulse_output_one) && en[PULSE_BIT] |-> ##[2:6] !irq_out_low)
    else $error("pulse edge did not raise interrupt");
  a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
    else $error("read data outside its cycle");
endmodule : crossing_pulse_irq_bits_chk

// *** sim/crossing_pulse_irq_bits_test.sv ***
// self-checking bench for the pulse and crossing interrupt flags
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
module crossing_pulse_irq_bits_test;
  import irq_bits_pkg::*;
  localparam int SW  = 24;  // sample width
  localparam int THR = 3;   // crossing threshold used
  logic          core_clk, rstn, reg_wr, reg_rd, sample_valid;
  logic          pulse_output_one, irq_out_low;
  logic [3:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata, en_v, exp_v;
  logic [SW-1:0] cur [4];  // a, b, c, neutral samples
  int            num_errors, cmp_count, irq_falls, m;
  integer        seed;

  crossing_pulse_irq_bits #(.SAMPLE_W(SW)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pulse_output_one(pulse_output_one),
    .phase_a_current(cur[0]), .phase_b_current(cur[1]),
    .phase_c_current(cur[2]), .neutral_current(cur[3]),
    .sample_valid(sample_valid), .irq_out_low(irq_out_low));
  irq_host_model i_host (.core_clk(core_clk), .rstn(rstn),
    .irq_out_low(irq_out_low), .irq_falls(irq_falls));

  // compare and report
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // one write, then one idle edge
  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  // one read, data checked in the following cycle
  task automatic rd(logic [3:0] a, logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("read data", exp, reg_rdata);
    @(posedge core_clk);
  endtask : rd
  // one pulse, long enough to pass the synchroniser
  task automatic pulse();
    pulse_output_one <= 1'b1;
    repeat (5) @(posedge core_clk);
    pulse_output_one <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask : pulse
  // +1, -m, +1 on the chosen channels, zero elsewhere
  task automatic xing(logic [3:0] msk, int m);
    logic [SW-1:0] v [3];
    v = '{SW'(1), -SW'(m), SW'(1)};
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 4; c++) cur[c] <= msk[c] ? v[s] : '0;
      sample_valid <= 1'b1;
      @(posedge core_clk);
    end
    sample_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : xing
  // peak of the trial above the threshold
  function automatic logic exp_hit(int m);
    return ((m > 1) ? m : 1) > THR;
  endfunction : exp_hit
  // print counts and verdict, then stop
  task automatic summarize();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    summarize();
  end
  // main sequence
  initial begin
    seed = 32'hB694;
    {rstn, reg_wr, reg_rd, pulse_output_one, sample_valid} = '0;
    {reg_addr, reg_wdata} = '0;
    cur = '{default: '0};
    num_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk("irq idle", 32'h1, irq_out_low);
    for (int a = 0; a < 5; a++) rd((a == 4) ? 4'hF : 4'(a), 32'h0);
    wr(REG_ENABLE, 32'h100);
    pulse();
    chk("irq pulse", 32'h0, irq_out_low);
    // live index ignores writes, shows the pending request
    wr(REG_LIVE, 32'hFFFFFFFF);
    rd(REG_LIVE, 32'h2);
    rd(REG_ENABLE, 32'h100);
    rd(REG_STATUS, 32'h100);
    chk("irq read", 32'h1, irq_out_low);
    pulse();
    wr(REG_STATUS, 32'h100);
    chk("irq w1c", 32'h1, irq_out_low);
    rd(REG_STATUS, 32'h0);
    chk("host irq count", 32'h2, irq_falls);
    wr(REG_THRESH, THR);
    rd(REG_THRESH, THR);
    wr(REG_ENABLE, FLAG_MASK);
    xing(4'h3, 5);
    wr(REG_STATUS, 32'h10);
    chk("irq one left", 32'h0, irq_out_low);
    wr(REG_STATUS, 32'h20);
    chk("irq none left", 32'h1, irq_out_low);
    for (int t = 0; t < 24; t++) begin
      m = ($random(seed) & 7) + 1;
      en_v = $random(seed) & FLAG_MASK;
      wr(REG_ENABLE, en_v);
      xing(4'(1 << (t % 4)), m);
      exp_v = exp_hit(m) ? 32'(1 << (CROSS_LO_BIT + t % 4)) : 32'h0;
      chk("irq cross", 32'((exp_v & en_v) == 0), irq_out_low);
      rd(REG_STATUS, exp_v);
    end
    // mask a pending pulse flag, unmask it, then reset mid-run
    wr(REG_ENABLE, FLAG_MASK);
    pulse();
    wr(REG_ENABLE, 32'h0);
    chk("irq masked", 32'h1, irq_out_low);
    wr(REG_ENABLE, FLAG_MASK);
    chk("irq unmasked", 32'h0, irq_out_low);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk("irq after reset", 32'h1, irq_out_low);
    rd(REG_STATUS, 32'h0);
    rd(REG_ENABLE, 32'h0);
    summarize();
  end
endmodule : crossing_pulse_irq_bits_test

bind crossing_pulse_irq_bits crossing_pulse_irq_bits_chk i_chk (
  .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pulse_output_one(pulse_output_one),
  .irq_out_low(irq_out_low));
